// File: hw/sclksw_defines.vh
`ifndef SCLKSW_DEFINES_VH
`define SCLKSW_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define SCLKSW_OFS_CRYSTAL_CTRL 5'h00
`define SCLKSW_OFS_CPU_SEL 5'h04
`define SCLKSW_OFS_WATCH_CTRL 5'h08
`define SCLKSW_OFS_SLOW_DIV 5'h0C
`define SCLKSW_OFS_STATUS 5'h10

// ==========================================================================
// Field positions
`define SCLKSW_CRYSTAL_SEL_BIT 0
`define SCLKSW_BIAS_LSB 4
`define SCLKSW_BIAS_MSB 7
`define SCLKSW_CPU_FAST_BIT 0
`define SCLKSW_WATCH_EN_BIT 0
`define SCLKSW_WATCH_EXT_BIT 1
`define SCLKSW_DIV_FRAC_LSB 0
`define SCLKSW_DIV_FRAC_MSB 7
`define SCLKSW_DIV_INT_LSB 8
`define SCLKSW_DIV_INT_MSB 15
`define SCLKSW_ST_ON_CRYSTAL_BIT 0
`define SCLKSW_ST_FAILOVER_BIT 1
`define SCLKSW_ST_FLASH_BIT 2
`define SCLKSW_ST_CPU_FAST_BIT 3

// ==========================================================================
// Reset values
`define SCLKSW_RST_BIAS 4'hF
`define SCLKSW_RST_DIV_INT 8'h0A
`define SCLKSW_RST_DIV_FRAC 8'h00

// ==========================================================================
// Timing counts
`define SCLKSW_MISS_LIMIT 4'h4

`endif

// File: hw/sclksw_clock_switch.v
`include "sclksw_defines.vh"

module sclksw_clock_switch #(
   parameter MISS_W = 4,
   parameter DIV_W = 8
) (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Oscillators and pins
   input wire fastRcOsc,
   input wire mainCrystalOsc,
   input wire slowRcOsc,
   input wire watchCrystalOsc,
   input wire watchCrystalPinB,
   input wire flashBusy,
   // Avalon-MM slave
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   // Clocks and controls out
   output reg mainSystemClock,
   output reg periphClock,
   output reg cpuCoreClock,
   output reg millisecondReferenceClock,
   output reg watchClock,
   output reg watchPinBDigital,
   output reg [3:0] crystalBias,
   output reg nmiReq
);

   // ==========================================================================
   // Registers
   reg crystalSel_q;
   reg cpuFast_q;
   reg watchEn_q;
   reg watchExt_q;
   reg [DIV_W-1:0] divInt_q;
   reg [DIV_W-1:0] divFrac_q;
   reg failFlag_q;
   reg sysSrc_q;
   reg cpuSrc_q;
   reg [3:0] edgePrev_q;
   reg [MISS_W-1:0] missCnt_q;
   reg [DIV_W-1:0] divCnt_q;
   reg [DIV_W-1:0] period_q;
   reg [DIV_W-1:0] fracAcc_q;

   wire [3:0] edgeIn = {mainSystemClock, slowRcOsc, mainCrystalOsc, fastRcOsc};
   wire [3:0] edgeRise;
   wire fastRise = edgeRise[0];
   wire xtalRise = edgeRise[1];
   wire slowRise = edgeRise[2];
   wire sysRise = edgeRise[3];
   wire xtalDead = (missCnt_q >= `SCLKSW_MISS_LIMIT);
   wire failover = crystalSel_q & xtalDead;
   wire access = (read | write) & waitrequest;
   wire wrStrobe = write & ~waitrequest;
   wire rdStrobe = read & waitrequest;
   wire hitCrystal = (address == `SCLKSW_OFS_CRYSTAL_CTRL);
   wire hitCpu = (address == `SCLKSW_OFS_CPU_SEL);
   wire hitWatch = (address == `SCLKSW_OFS_WATCH_CTRL);
   wire hitDiv = (address == `SCLKSW_OFS_SLOW_DIV);
   wire hitStatus = (address == `SCLKSW_OFS_STATUS);

   // ==========================================================================
   // Rising-edge detectors, one per sampled clock level
   // Every previous level resets low, the idle level of each source, so no
   // false edge is seen right after reset.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gEdge
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               edgePrev_q[g] <= 1'b0;
            end else begin
               edgePrev_q[g] <= edgeIn[g];
            end
         end
         assign edgeRise[g] = edgeIn[g] & ~edgePrev_q[g];
      end
   endgenerate

   // ==========================================================================
   // Missing-edge monitor
   // Counts fast RC edges between crystal edges; a stuck crystal saturates it.
   // Counting goes on until the system clock has left the crystal, so that a
   // crystal stuck high still lets the failover bypass its low-phase wait.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         missCnt_q <= {MISS_W{1'b0}};
      end else if (xtalRise || (!crystalSel_q && !sysSrc_q)) begin
         missCnt_q <= {MISS_W{1'b0}};
      end else if (fastRise && !xtalDead) begin
         missCnt_q <= missCnt_q + {{(MISS_W-1){1'b0}}, 1'b1};
      end
   end

   // ==========================================================================
   // Software registers
   // Failover wins over a software write of the select bit in the same cycle.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crystalSel_q <= 1'b0;
         crystalBias <= `SCLKSW_RST_BIAS;
      end else begin
         if (failover) begin
            crystalSel_q <= 1'b0;
         end else if (wrStrobe && hitCrystal) begin
            crystalSel_q <= writedata[`SCLKSW_CRYSTAL_SEL_BIT];
         end
         if (wrStrobe && hitCrystal) begin
            crystalBias <= writedata[`SCLKSW_BIAS_MSB:`SCLKSW_BIAS_LSB];
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpuFast_q <= 1'b0;
      end else if (wrStrobe && hitCpu) begin
         cpuFast_q <= writedata[`SCLKSW_CPU_FAST_BIT];
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         watchEn_q <= 1'b0;
         watchExt_q <= 1'b0;
      end else if (wrStrobe && hitWatch) begin
         watchEn_q <= writedata[`SCLKSW_WATCH_EN_BIT];
         watchExt_q <= writedata[`SCLKSW_WATCH_EXT_BIT];
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divInt_q <= `SCLKSW_RST_DIV_INT;
         divFrac_q <= `SCLKSW_RST_DIV_FRAC;
      end else if (wrStrobe && hitDiv) begin
         divFrac_q <= writedata[`SCLKSW_DIV_FRAC_MSB:`SCLKSW_DIV_FRAC_LSB];
         divInt_q <= writedata[`SCLKSW_DIV_INT_MSB:`SCLKSW_DIV_INT_LSB];
      end
   end

   // A failover in the same cycle as a clear keeps the flag set.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         failFlag_q <= 1'b0;
      end else if (failover) begin
         failFlag_q <= 1'b1;
      end else if (wrStrobe && hitStatus && writedata[`SCLKSW_ST_FAILOVER_BIT]) begin
         failFlag_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Avalon-MM slave: one wait state on every access
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else begin
         waitrequest <= ~access;
         if (rdStrobe) begin
            case (address)
               `SCLKSW_OFS_CRYSTAL_CTRL: begin
                  readdata <= {24'h00_0000, crystalBias, 3'b000, crystalSel_q};
               end
               `SCLKSW_OFS_CPU_SEL: begin
                  readdata <= {31'h0000_0000, cpuFast_q};
               end
               `SCLKSW_OFS_WATCH_CTRL: begin
                  readdata <= {30'h0000_0000, watchExt_q, watchEn_q};
               end
               `SCLKSW_OFS_SLOW_DIV: begin
                  readdata <= {16'h0000, divInt_q, divFrac_q};
               end
               `SCLKSW_OFS_STATUS: begin
                  readdata <= {28'h000_0000, cpuSrc_q, flashBusy, failFlag_q, sysSrc_q};
               end
               default: begin
                  readdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Glitch-free source muxes
   // A source changes only while the output is low and the new source is low,
   // so no shortened high phase can appear. A dead crystal may sit high, so
   // failover skips the wait on the old source; that high phase is already long.
   wire sysTarget = crystalSel_q;
   wire sysNewLevel = sysTarget ? mainCrystalOsc : fastRcOsc;
   wire sysSwitch = (sysTarget != sysSrc_q) && !sysNewLevel
      && (!mainSystemClock || xtalDead);
   wire sysSrcNext = sysSwitch ? sysTarget : sysSrc_q;

   // Forced mode picks whichever source runs at 12 MHz for the current oscillator.
   wire cpuTarget = flashBusy ? ~sysSrc_q : cpuFast_q;
   wire cpuNewLevel = cpuTarget ? mainSystemClock : periphClock;
   wire cpuSwitch = (cpuTarget != cpuSrc_q) && !cpuNewLevel && !cpuCoreClock;
   wire cpuSrcNext = cpuSwitch ? cpuTarget : cpuSrc_q;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sysSrc_q <= 1'b0;
         mainSystemClock <= 1'b0;
      end else begin
         sysSrc_q <= sysSrcNext;
         mainSystemClock <= sysSrcNext ? mainCrystalOsc : fastRcOsc;
      end
   end

   // Toggling on system clock rises keeps the ratio exact after any switch.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         periphClock <= 1'b0;
      end else if (sysRise) begin
         periphClock <= ~periphClock;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpuSrc_q <= 1'b0;
         cpuCoreClock <= 1'b0;
      end else begin
         cpuSrc_q <= cpuSrcNext;
         cpuCoreClock <= cpuSrcNext ? mainSystemClock : periphClock;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nmiReq <= 1'b0;
      end else begin
         nmiReq <= failover;
      end
   end

   // ==========================================================================
   // Fractional-N divider for the millisecond reference
   // Each period is divInt or divInt+1 slow RC edges, the extra edge taken on
   // carry out of the fraction accumulator, so the average is int + frac/256.
   wire [DIV_W:0] fracSum = {1'b0, fracAcc_q} + {1'b0, divFrac_q};
   wire [DIV_W-1:0] nextPeriod = divInt_q + {{(DIV_W-1){1'b0}}, fracSum[DIV_W]};
   wire periodEnd = (divCnt_q + {{(DIV_W-1){1'b0}}, 1'b1}) >= period_q;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= {DIV_W{1'b0}};
         fracAcc_q <= {DIV_W{1'b0}};
         period_q <= `SCLKSW_RST_DIV_INT;
         millisecondReferenceClock <= 1'b0;
      end else if (slowRise) begin
         if (periodEnd) begin
            divCnt_q <= {DIV_W{1'b0}};
            fracAcc_q <= fracSum[DIV_W-1:0];
            period_q <= nextPeriod;
            millisecondReferenceClock <= 1'b1;
         end else begin
            divCnt_q <= divCnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
            millisecondReferenceClock <= (divCnt_q + {{(DIV_W-1){1'b0}}, 1'b1})
               < {1'b0, period_q[DIV_W-1:1]};
         end
      end
   end

   // ==========================================================================
   // Watch clock source
   // The enable is only changed by software, so gating here needs no handshake.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         watchClock <= 1'b0;
         watchPinBDigital <= 1'b0;
      end else begin
         watchPinBDigital <= watchExt_q;
         watchClock <= watchEn_q & (watchExt_q ? watchCrystalPinB : watchCrystalOsc);
      end
   end

endmodule // sclksw_clock_switch

// File: test/sclksw_properties.sv
module sclksw_properties (
   // Clock, reset and bus handshake
   input wire clock,
   input wire rst_n,
   input wire read,
   input wire write,
   input wire waitrequest,
   // Clocks and controls
   input wire mainSystemClock,
   input wire periphClock,
   input wire cpuCoreClock,
   input wire nmiReq,
   input wire [3:0] crystalBias
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ====================================
   // Bus, clock tree, failover and reset checks
   chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered next cycle");
   chk_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("wait state low longer than one cycle");
   chk_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("answer without request");
   chk_nmi_pulse: assert property (nmiReq |=> !nmiReq)
      else $error("failover interrupt longer than one cycle");
   chk_periph_follow: assert property ($rose(mainSystemClock) |=> $changed(periphClock))
      else $error("peripheral clock missed a system clock rise");
   chk_periph_hold: assert property (!$rose(mainSystemClock) |=> $stable(periphClock))
      else $error("peripheral clock toggled without system rise");
   chk_cpu_source: assert property (cpuCoreClock |-> $past(mainSystemClock) || $past(periphClock))
      else $error("cpu clock high while no source was high");
   chk_sys_no_runt: assert property ($rose(mainSystemClock) |=> mainSystemClock)
      else $error("runt high pulse on system clock");
   chk_sys_no_gap: assert property ($fell(mainSystemClock) |=> !mainSystemClock)
      else $error("runt low pulse on system clock");
   chk_bias_reset: assert property ($rose(rst_n) |-> crystalBias == 4'hF)
      else $error("crystal bias not at reset value");
endmodule // sclksw_properties

bind sclksw_clock_switch sclksw_properties sclksw_properties_inst (.clock, .rst_n, .read, .write,
   .waitrequest, .mainSystemClock, .periphClock, .cpuCoreClock, .nmiReq, .crystalBias);

// File: test/sclksw_osc_model.sv
module sclksw_osc_model #(
   parameter int FAST_HALF = 5,
   parameter int XTAL_HALF = 3,
   parameter int SLOW_HALF = 2
) (
   // Control
   input wire logic clock,
   input wire logic crystalStop,
   // Oscillator levels
   output logic fastRcOsc = 1'b0,
   output logic mainCrystalOsc = 1'b0,
   output logic slowRcOsc = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int fastCnt = 0;
   int xtalCnt = 0;
   int slowCnt = 0;
   // ====================================
   // Free-running oscillators; a dead crystal parks low like a stopped resonator.
   always @(posedge clock) begin
      fastCnt <= (fastCnt == FAST_HALF - 1) ? 0 : fastCnt + 1;
      xtalCnt <= (xtalCnt == XTAL_HALF - 1) ? 0 : xtalCnt + 1;
      slowCnt <= (slowCnt == SLOW_HALF - 1) ? 0 : slowCnt + 1;
      if (fastCnt == FAST_HALF - 1) fastRcOsc <= !fastRcOsc;
      if (slowCnt == SLOW_HALF - 1) slowRcOsc <= !slowRcOsc;
      if (crystalStop) mainCrystalOsc <= 1'b0;
      else if (xtalCnt == XTAL_HALF - 1) mainCrystalOsc <= !mainCrystalOsc;
   end
endmodule // sclksw_osc_model

// File: test/system_clock_switching_tb.sv
module system_clock_switching_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, read = 0, write = 0, flashBusy = 0, crystalStop = 0;
   logic watchCrystalPinB = 0, watchCrystalOsc = 0, waitrequest, mainSystemClock, periphClock;
   logic millisecondReferenceClock, watchClock, watchPinBDigital, nmiReq, cpuCoreClock;
   logic fastRcOsc, mainCrystalOsc, slowRcOsc;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0000_0000, readdata, q;
   logic [3:0] crystalBias;
   wire [2:0] probe = {periphClock, millisecondReferenceClock, mainSystemClock};
   int miscompares = 0, compares = 0, nmiCount = 0, n;
   // Rows: write flag, address, write data, expected read data.
   logic [69:0] rows [8] = '{{1'b0, 5'h00, 32'h0000_0000, 32'h0000_00F0},
      {1'b0, 5'h0C, 32'h0000_0000, 32'h0000_0A00}, {1'b0, 5'h14, 32'h0000_0000, 32'h0000_0000},
      {1'b0, 5'h08, 32'h0000_0000, 32'h0000_0000}, {1'b1, 5'h04, 32'h0000_0001, 32'h0000_0000},
      {1'b0, 5'h04, 32'h0000_0000, 32'h0000_0001}, {1'b1, 5'h00, 32'h0000_0031, 32'h0000_0000},
      {1'b0, 5'h00, 32'h0000_0000, 32'h0000_0031}};
   always #4 clock = !clock;
   always @(posedge clock) if (nmiReq === 1'b1) nmiCount <= nmiCount + 1;
   sclksw_osc_model sclksw_osc_model_inst (.clock, .crystalStop, .fastRcOsc, .mainCrystalOsc,
      .slowRcOsc);
   sclksw_clock_switch sclksw_clock_switch_inst (.clock, .rst_n, .fastRcOsc, .mainCrystalOsc,
      .slowRcOsc, .watchCrystalOsc, .watchCrystalPinB, .flashBusy, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .mainSystemClock, .periphClock,
      .cpuCoreClock, .millisecondReferenceClock, .watchClock, .watchPinBDigital, .crystalBias,
      .nmiReq);
   // ====================================
   // Shared tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // The master holds its request until it samples waitrequest low.
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task hiRun(input int i);
      n = 0;
      @(posedge clock iff probe[i] === 1'b0);
      @(posedge clock iff probe[i] === 1'b1);
      while (probe[i] === 1'b1) begin
         @(posedge clock);
         n++;
      end
   endtask
   // Counts cycles where the cpu clock differs from the chosen source one cycle earlier.
   task follow(input int i);
      logic prev;
      n = 0;
      prev = probe[i];
      repeat (40) begin
         @(posedge clock);
         if (cpuCoreClock !== prev) n++;
         prev = probe[i];
      end
   endtask
   task report_and_stop;
      $display("Compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      report_and_stop;
   end
   // ====================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      hiRun(0); chk(n, 5);
      foreach (rows[i]) begin
         bus(rows[i][69], rows[i][68:64], rows[i][63:32]);
         if (!rows[i][69]) chk(q, rows[i][31:0]);
      end
      repeat (30) @(posedge clock);
      hiRun(0); chk(n, 3);
      chk(crystalBias, 4'h3);
      follow(0); chk(n, 0);
      flashBusy <= 1'b1;
      repeat (30) @(posedge clock);
      follow(2); chk(n, 0);
      flashBusy <= 1'b0;
      watchCrystalPinB <= 1'b1;
      repeat (5) @(posedge clock);
      chk(watchClock, 1'b0);
      bus(1'b1, 5'h08, 32'h0000_0003);
      repeat (5) @(posedge clock);
      chk(watchClock, 1'b1);
      chk(watchPinBDigital, 1'b1);
      // Crystal mode: software keeps pin b analog, and the crystal level must pass.
      watchCrystalOsc <= 1'b1;
      watchCrystalPinB <= 1'b0;
      bus(1'b1, 5'h08, 32'h0000_0001);
      repeat (5) @(posedge clock);
      chk(watchClock, 1'b1);
      chk(watchPinBDigital, 1'b0);
      hiRun(1); chk(n, 20);
      bus(1'b1, 5'h0C, 32'h0000_0880);
      bus(1'b0, 5'h0C, 32'h0000_0000); chk(q, 32'h0000_0880);
      hiRun(1); chk(n, 16);
      crystalStop <= 1'b1;
      repeat (80) @(posedge clock);
      chk(nmiCount, 1);
      bus(1'b0, 5'h00, 32'h0000_0000); chk(q, 32'h0000_0030);
      bus(1'b0, 5'h10, 32'h0000_0000); chk(q, 32'h0000_000A);
      bus(1'b1, 5'h10, 32'h0000_0002);
      bus(1'b0, 5'h10, 32'h0000_0000); chk(q, 32'h0000_0008);
      hiRun(0); chk(n, 5);
      bus(1'b1, 5'h04, 32'h0000_0000);
      repeat (30) @(posedge clock);
      follow(2); chk(n, 0);
      flashBusy <= 1'b1;
      repeat (30) @(posedge clock);
      follow(0); chk(n, 0);
      bus(1'b0, 5'h10, 32'h0000_0000); chk(q, 32'h0000_000C);
      flashBusy <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, 5'h00, 32'h0000_0000); chk(q, 32'h0000_00F0);
      report_and_stop;
   end
endmodule // system_clock_switching_tb
